//--- design/sdcrp_top.sv
`timescale 1ns/1ps
module sdcrp_top (
    input  wire logic                                   CLOCK,
    input  wire logic                                   RESETN,
    input  wire logic                                   CKE,
    input  wire logic                                   CS_N,
    input  wire logic                                   RAS_N,
    input  wire logic                                   CAS_N,
    input  wire logic                                   WE_N,
    input  wire logic [sdcrp_pkg::BANK_W-1:0]           BA,
    input  wire logic [sdcrp_pkg::ADDR_W-1:0]           ADDR,
    input  wire logic [sdcrp_pkg::NLANE-1:0]            DQM,
    input  wire logic [sdcrp_pkg::DATA_W-1:0]           DQ_IN,
    output logic      [sdcrp_pkg::DATA_W-1:0]           DQ_OUT,
    output logic      [sdcrp_pkg::NLANE-1:0]            DQ_OE,
    output logic      [sdcrp_pkg::NBANK-1:0]            BANK_ACTIVE,
    output logic      [sdcrp_pkg::ADDR_W-1:0]           MODE_WORD
);
    localparam int RK = sdcrp_pkg::ROW_KEEP;

    sdcrp_pkg::sdcrp_state_t                st_ff;
    sdcrp_pkg::sdcrp_state_t                nxt_st;
    sdcrp_pkg::sdcrp_cmd_t                  cmd;
    logic                                   rd_en;
    logic [sdcrp_pkg::MEM_AW-1:0]           rd_addr;
    logic [sdcrp_pkg::DATA_W-1:0]           rd_data;
    logic                                   wr_en;
    logic [sdcrp_pkg::NLANE-1:0]            wr_be;
    logic [sdcrp_pkg::MEM_AW-1:0]           wr_addr;

    // ==========================================================
    // storage
    sdcrp_mem sdcrp_mem_inst (
        .clk     (CLOCK),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .wr_en   (wr_en),
        .wr_be   (wr_be),
        .wr_addr (wr_addr),
        .wr_data (DQ_IN)
    );

    // ==========================================================
    // command decode and next state
    always_comb begin
        cmd = sdcrp_pkg::sdcrp_decode(CS_N, RAS_N, CAS_N, WE_N);
        nxt_st  = st_ff;
        rd_en   = 1'b0;
        rd_addr = '0;
        wr_en   = 1'b0;
        wr_be   = '0;
        wr_addr = '0;
        // clock enable is not registered: it qualifies this very edge,
        // so a low level freezes everything including the storage
        if (CKE) begin
            nxt_st.dqm_d1 = DQM;
            // mask seen with an access reaches the pins one edge after
            // the data word is fetched, i.e. two clocks after sampling
            nxt_st.dq_oe = st_ff.rd_v1 ? ~st_ff.dqm_d1 : '0;
            if (st_ff.rd_v1) begin
                nxt_st.dq_out = rd_data;
            end
            // ongoing read burst
            if (st_ff.rd_act) begin
                rd_en   = 1'b1;
                rd_addr = {st_ff.rd_bank,
                           st_ff.rows[st_ff.rd_bank][RK-1:0],
                           st_ff.rd_col};
                nxt_st.rd_col = st_ff.rd_col + 8'h01;
                nxt_st.rd_cnt = st_ff.rd_cnt - 2'h1;
                if (st_ff.rd_cnt == sdcrp_pkg::BURST_LAST) begin
                    nxt_st.rd_act = 1'b0;
                    if (st_ff.rd_ap) begin
                        nxt_st.open[st_ff.rd_bank] = 1'b0;
                    end
                end
            end
            // ongoing write burst, mask applies to data of this edge
            if (st_ff.wr_act) begin
                wr_en   = 1'b1;
                wr_be   = ~DQM;
                wr_addr = {st_ff.wr_bank,
                           st_ff.rows[st_ff.wr_bank][RK-1:0],
                           st_ff.wr_col};
                nxt_st.wr_col = st_ff.wr_col + 8'h01;
                nxt_st.wr_cnt = st_ff.wr_cnt - 2'h1;
                if (st_ff.wr_cnt == sdcrp_pkg::BURST_LAST) begin
                    nxt_st.wr_act = 1'b0;
                    if (st_ff.wr_ap) begin
                        nxt_st.open[st_ff.wr_bank] = 1'b0;
                    end
                end
            end
            case (cmd)
                sdcrp_pkg::CMD_ACTIVE: begin
                    nxt_st.open[BA] = 1'b1;
                    nxt_st.rows[BA] = ADDR;
                end
                sdcrp_pkg::CMD_READ: begin
                    // a new read cuts any running burst short
                    wr_en   = 1'b0;
                    rd_en   = 1'b1;
                    rd_addr = {BA, st_ff.rows[BA][RK-1:0],
                               ADDR[sdcrp_pkg::COL_W-1:0]};
                    nxt_st.wr_act  = 1'b0;
                    nxt_st.rd_act  = 1'b1;
                    nxt_st.rd_bank = BA;
                    nxt_st.rd_col  = ADDR[sdcrp_pkg::COL_W-1:0] + 8'h01;
                    nxt_st.rd_cnt  = sdcrp_pkg::BURST_MORE;
                    nxt_st.rd_ap   = ADDR[sdcrp_pkg::AP_BIT];
                end
                sdcrp_pkg::CMD_WRITE: begin
                    rd_en   = 1'b0;
                    wr_en   = 1'b1;
                    wr_be   = ~DQM;
                    wr_addr = {BA, st_ff.rows[BA][RK-1:0],
                               ADDR[sdcrp_pkg::COL_W-1:0]};
                    nxt_st.rd_act  = 1'b0;
                    nxt_st.wr_act  = 1'b1;
                    nxt_st.wr_bank = BA;
                    nxt_st.wr_col  = ADDR[sdcrp_pkg::COL_W-1:0] + 8'h01;
                    nxt_st.wr_cnt  = sdcrp_pkg::BURST_MORE;
                    nxt_st.wr_ap   = ADDR[sdcrp_pkg::AP_BIT];
                end
                sdcrp_pkg::CMD_BTERM: begin
                    // truncation takes effect on this edge; no auto close unless this edge is the last beat
                    rd_en = 1'b0;
                    wr_en = 1'b0;
                    nxt_st.rd_act = 1'b0;
                    nxt_st.wr_act = 1'b0;
                end
                sdcrp_pkg::CMD_PRECHARGE: begin
                    if (ADDR[sdcrp_pkg::AP_BIT]) begin
                        nxt_st.open = '0;
                    end else begin
                        nxt_st.open[BA] = 1'b0;
                    end
                end
                sdcrp_pkg::CMD_LOADMODE: begin
                    nxt_st.mode = ADDR;
                end
                default: begin
                end
            endcase
            nxt_st.rd_v1 = rd_en;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff <= sdcrp_pkg::STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign DQ_OUT      = st_ff.dq_out;
    assign DQ_OE       = st_ff.dq_oe;
    assign BANK_ACTIVE = st_ff.open;
    assign MODE_WORD   = st_ff.mode;

    // ==========================================================
    // checks
    chk_read_mask_delay: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && rd_en) ##1 CKE |=> (DQ_OE == ~$past(DQM, 2)))
        else $error("read lane enable does not follow mask of two clocks ago");

    chk_deselect_hold: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && CS_N && !st_ff.rd_act && !st_ff.wr_act)
        |=> ($stable(BANK_ACTIVE) && $stable(MODE_WORD)))
        else $error("state changed while chip deselected");

    chk_activate_row: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && !CS_N && !RAS_N && CAS_N && WE_N)
        |=> (BANK_ACTIVE[$past(BA)] && st_ff.rows[$past(BA)] == $past(ADDR)))
        else $error("activate did not open bank with its row");

    chk_precharge_all: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_PRECHARGE && ADDR[sdcrp_pkg::AP_BIT])
        |=> (BANK_ACTIVE == 4'h0))
        else $error("precharge all left a bank open");

    chk_precharge_one: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_PRECHARGE && !ADDR[sdcrp_pkg::AP_BIT]
         && !st_ff.rd_act && !st_ff.wr_act)
        |=> (BANK_ACTIVE == ($past(BANK_ACTIVE) & ~(4'h1 << $past(BA)))))
        else $error("single-bank precharge hit the wrong banks");

    chk_mode_load: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_LOADMODE) |=> (MODE_WORD == $past(ADDR)))
        else $error("mode word not taken from address");

    chk_clock_freeze: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        !CKE |=> ($stable(st_ff) && !$past(wr_en) && !$past(rd_en)))
        else $error("state moved on an edge with clock enable low");

    chk_write_mask: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_WRITE) |-> (wr_en && wr_be == ~DQM))
        else $error("write lanes not gated by same-cycle mask");

    chk_auto_close: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_READ && ADDR[sdcrp_pkg::AP_BIT])
        ##1 (CKE && cmd == sdcrp_pkg::CMD_NOP) [*3]
        |=> !BANK_ACTIVE[$past(BA, 4)])
        else $error("auto precharge did not close row after burst");

    // ==========================================================
    // checks on decode and bank state
    chk_deselect_bus: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        CS_N |-> (cmd == sdcrp_pkg::CMD_INHIBIT))
        else $error("deselected chip decoded a command");

    chk_rows_hold: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (cmd != sdcrp_pkg::CMD_ACTIVE) |=> $stable(st_ff.rows))
        else $error("row latch changed without activate");

    chk_open_needs_act: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (!CKE || cmd != sdcrp_pkg::CMD_ACTIVE)
        |=> ((BANK_ACTIVE & ~$past(BANK_ACTIVE)) == 4'h0))
        else $error("bank opened without activate");

    chk_mode_hold: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (cmd != sdcrp_pkg::CMD_LOADMODE) |=> $stable(MODE_WORD))
        else $error("mode word changed without load");

    chk_refresh_hold: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_REFRESH
         && !st_ff.rd_act && !st_ff.wr_act)
        |=> ($stable(BANK_ACTIVE) && $stable(MODE_WORD)))
        else $error("refresh disturbed bank or mode state");

    chk_bterm_stop: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_BTERM)
        |-> (!rd_en && !wr_en) ##1 (!st_ff.rd_act && !st_ff.wr_act))
        else $error("burst terminate left a burst running");

    // ==========================================================
    // checks on the data path
    chk_read_fetch: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_READ)
        |-> (rd_en && !wr_en && rd_addr == {BA, st_ff.rows[BA][RK-1:0],
                                           ADDR[sdcrp_pkg::COL_W-1:0]}))
        else $error("read fetched from the wrong location");

    chk_read_burst: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_READ) |=> st_ff.rd_act)
        else $error("read command did not start a burst");

    chk_burst_end: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_READ)
        ##1 (CKE && cmd == sdcrp_pkg::CMD_NOP) [*3]
        |=> !st_ff.rd_act)
        else $error("read burst did not end after four beats");

    chk_mask_capture: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        CKE |=> (st_ff.dqm_d1 == $past(DQM)))
        else $error("byte mask not registered on a valid edge");

    chk_oe_idle: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && !st_ff.rd_v1) |=> (DQ_OE == 4'h0))
        else $error("lanes driven with no read beat due");

    chk_read_data: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && st_ff.rd_v1) |=> (DQ_OUT == $past(rd_data)))
        else $error("read beat did not reach the data pins");

    chk_write_beats: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && st_ff.wr_act && cmd == sdcrp_pkg::CMD_NOP)
        |-> (wr_en && wr_be == ~DQM))
        else $error("later write beat not gated by its own mask");

    chk_write_addr: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CKE && cmd == sdcrp_pkg::CMD_WRITE)
        |-> (wr_addr == {BA, st_ff.rows[BA][RK-1:0],
                         ADDR[sdcrp_pkg::COL_W-1:0]}))
        else $error("write aimed at the wrong location");

    chk_no_write_idle: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (!st_ff.wr_act && cmd != sdcrp_pkg::CMD_WRITE) |-> !wr_en)
        else $error("storage written with no write burst");

endmodule

//--- design/sdcrp_pkg.sv
package sdcrp_pkg;

    // ==========================================================
    // geometry
    localparam int ADDR_W   = 11;
    localparam int COL_W    = 8;
    localparam int BANK_W   = 2;
    localparam int NBANK    = 4;
    localparam int DATA_W   = 32;
    localparam int NLANE    = 4;
    localparam int LANE_W   = 8;
    // only the low row bits reach the storage array, so rows alias
    localparam int ROW_KEEP = 2;
    localparam int MEM_AW   = BANK_W + ROW_KEEP + COL_W;
    localparam int AP_BIT   = 10;

    // ==========================================================
    // burst: beats that follow the one issued with the command
    localparam logic [1:0] BURST_MORE = 2'h3;
    localparam logic [1:0] BURST_LAST = 2'h1;

    // ==========================================================
    // commands
    typedef enum {
        CMD_INHIBIT,
        CMD_NOP,
        CMD_ACTIVE,
        CMD_READ,
        CMD_WRITE,
        CMD_BTERM,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_LOADMODE
    } sdcrp_cmd_t;

    function automatic sdcrp_cmd_t sdcrp_decode(
        input logic cs_n,
        input logic ras_n,
        input logic cas_n,
        input logic we_n
    );
        sdcrp_cmd_t c;
        c = CMD_INHIBIT;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h7:    c = CMD_NOP;
                3'h3:    c = CMD_ACTIVE;
                3'h5:    c = CMD_READ;
                3'h4:    c = CMD_WRITE;
                3'h6:    c = CMD_BTERM;
                3'h2:    c = CMD_PRECHARGE;
                3'h1:    c = CMD_REFRESH;
                3'h0:    c = CMD_LOADMODE;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    // ==========================================================
    // state of the command and data path
    typedef struct packed {
        logic [NBANK-1:0]             open;
        logic [NBANK-1:0][ADDR_W-1:0] rows;
        logic [ADDR_W-1:0]            mode;
        logic                         rd_act;
        logic [BANK_W-1:0]            rd_bank;
        logic [COL_W-1:0]             rd_col;
        logic [1:0]                   rd_cnt;
        logic                         rd_ap;
        logic                         wr_act;
        logic [BANK_W-1:0]            wr_bank;
        logic [COL_W-1:0]             wr_col;
        logic [1:0]                   wr_cnt;
        logic                         wr_ap;
        logic [NLANE-1:0]             dqm_d1;
        logic                         rd_v1;
        logic [DATA_W-1:0]            dq_out;
        logic [NLANE-1:0]             dq_oe;
    } sdcrp_state_t;

    localparam sdcrp_state_t STATE_RESET = '0;

endpackage

//--- design/sdcrp_mem.sv
`timescale 1ns/1ps
module sdcrp_mem (
    input  wire logic                           clk,
    input  wire logic                           rd_en,
    input  wire logic [sdcrp_pkg::MEM_AW-1:0]   rd_addr,
    output logic      [sdcrp_pkg::DATA_W-1:0]   rd_data,
    input  wire logic                           wr_en,
    input  wire logic [sdcrp_pkg::NLANE-1:0]    wr_be,
    input  wire logic [sdcrp_pkg::MEM_AW-1:0]   wr_addr,
    input  wire logic [sdcrp_pkg::DATA_W-1:0]   wr_data
);
    localparam int DEPTH = 1 << sdcrp_pkg::MEM_AW;
    localparam int LW    = sdcrp_pkg::LANE_W;

    // ==========================================================
    // one byte-wide array per lane
    genvar g;
    generate
        for (g = 0; g < sdcrp_pkg::NLANE; g++) begin : g_lane
            logic [LW-1:0] mem [0:DEPTH-1];
            always_ff @(posedge clk) begin
                if (wr_en && wr_be[g]) begin
                    mem[wr_addr] <= wr_data[g*LW +: LW];
                end
                if (rd_en) begin
                    rd_data[g*LW +: LW] <= mem[rd_addr];
                end
            end
        end
    endgenerate

endmodule

//--- dv/sdcrp_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================
// controller side: one command per falling edge
module sdcrp_ctrl_model (
    input  wire logic        clk,
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [1:0]       ba,
    output logic [10:0]      addr,
    output logic [3:0]       dqm,
    output logic [31:0]      dq
);
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = '0;
        addr = '0;
        dqm = '0;
        dq = '0;
    end

    task automatic drive(input logic [3:0] code, input logic [1:0] b,
                         input logic [10:0] a, input logic [3:0] m,
                         input logic [31:0] d, input logic wd);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = code;
        ba = b;
        addr = a;
        dqm = m;
        // a released data bus must not look like the last word held
        dq = wd ? d : ~dq;
    endtask

    // applies to the next rising edge, as the pin is not registered
    task automatic set_cke(input logic v);
        cke = v;
    endtask
endmodule

//--- dv/test_sdram_command_and_read_path.sv
`timescale 1ns/1ps
module test_sdram_command_and_read_path;
    localparam logic [3:0] NOP = 4'h7;
    localparam logic [3:0] ACT = 4'h3;
    localparam logic [3:0] RD  = 4'h5;
    localparam logic [3:0] WR  = 4'h4;
    localparam logic [3:0] PRE = 4'h2;
    localparam logic [3:0] LMR = 4'h0;
    localparam logic [3:0] INH = 4'h8;
    localparam logic [3:0] BTM = 4'h6;
    localparam logic [3:0] RFS = 4'h1;

    logic        clock;
    logic        resetn;
    logic        cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0]  ba;
    logic [10:0] addr;
    logic [10:0] mode_word;
    logic [3:0]  dqm, dq_oe, bank_active;
    logic [31:0] dq_in, dq_out;
    int          fail_count, checks_done, cycles;

    sdcrp_top sdcrp_top_inst (
        .CLOCK(clock), .RESETN(resetn), .CKE(cke), .CS_N(cs_n),
        .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba),
        .ADDR(addr), .DQM(dqm), .DQ_IN(dq_in), .DQ_OUT(dq_out),
        .DQ_OE(dq_oe), .BANK_ACTIVE(bank_active), .MODE_WORD(mode_word)
    );

    sdcrp_ctrl_model sdcrp_ctrl_model_inst (
        .clk(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
        .dqm(dqm), .dq(dq_in)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] lm(input logic [3:0] x);
        return {{8{x[3]}}, {8{x[2]}}, {8{x[1]}}, {8{x[0]}}};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                       input logic [10:0] a);
        sdcrp_ctrl_model_inst.drive(c, b, a, 4'h0, 32'h0, 1'b0);
    endtask

    // write or read burst of four beats; read checks each beat
    task automatic burst(input logic rd, input logic [1:0] b,
                         input logic [7:0] col, input logic ap,
                         input logic [3:0][31:0] d,
                         input logic [3:0][3:0] m);
        logic [31:0] keep;
        for (int j = 0; j < (rd ? 7 : 4); j++) begin
            sdcrp_ctrl_model_inst.drive(j == 0 ? (rd ? RD : WR) : NOP, b,
                {ap, 2'h0, col}, j < 4 ? m[j] : 4'h0, d[j[1:0]],
                !rd);
            if (rd && j >= 2 && j < 6) begin
                keep = lm(~m[j-2]);
                check(32'(dq_oe), {28'h0, ~m[j-2]});
                check(dq_out & keep, d[j-2] & keep);
            end
            if (rd && j == 6)
                check(32'(dq_oe), 32'h0);
            if (rd && ap && j == 3)
                check(32'(bank_active[b]), 32'h1);
            if (rd && j == 4)
                check(32'(bank_active[b]), 32'(!ap));
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_mode();
        cmd(LMR, 2'h0, 11'h2A5);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(mode_word), 32'h2A5);
        cmd(INH, 2'h0, 11'h155);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(mode_word), 32'h2A5);
        cmd(LMR, 2'h0, 11'h0F0);
        sdcrp_ctrl_model_inst.set_cke(1'b0);
        cmd(NOP, 2'h0, 11'h0);
        sdcrp_ctrl_model_inst.set_cke(1'b1);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(mode_word), 32'h2A5);
        $display("test mode done");
    endtask

    task automatic t_banks();
        cmd(INH | ACT, 2'h0, 11'h7FF);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(bank_active), 32'h0);
        for (int b = 0; b < 4; b++) begin
            cmd(ACT, 2'(b), 11'h7FF);
            cmd(NOP, 2'h0, 11'h0);
            check(32'(bank_active), (32'h1 << (b + 1)) - 1);
        end
        cmd(RFS, 2'h0, 11'h0);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(bank_active), 32'hF);
        cmd(PRE, 2'h1, 11'h000);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(bank_active), 32'hD);
        cmd(PRE, 2'h1, 11'h400);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(bank_active), 32'h0);
        $display("test banks done");
    endtask

    // column wraps from FF to 00 inside each four-beat burst
    task automatic t_data();
        logic [3:0][31:0] pa, pb, e;
        logic [3:0][3:0]  wm, rm;
        pa = {32'h0F1E2D3C, 32'h4B5A6978, 32'h8796A5B4, 32'hC3D2E1F0};
        pb = {32'h13579BDF, 32'h2468ACE0, 32'hFEDCBA98, 32'h76543210};
        wm = {4'hF, 4'h5, 4'hA, 4'h0};
        rm = {4'h3, 4'hC, 4'h6, 4'h9};
        for (int k = 0; k < 4; k++)
            e[k] = (pb[k] & ~lm(wm[k])) | (pa[k] & lm(wm[k]));
        cmd(ACT, 2'h2, 11'h5A6);
        burst(1'b0, 2'h2, 8'hFE, 1'b0, pa, 16'h0);
        burst(1'b0, 2'h2, 8'hFE, 1'b0, pb, wm);
        burst(1'b1, 2'h2, 8'hFE, 1'b0, e, 16'h0);
        burst(1'b1, 2'h2, 8'hFE, 1'b1, e, rm);
        // terminate one beat into a fresh read
        cmd(ACT, 2'h2, 11'h5A6);
        cmd(RD, 2'h2, 11'h0FE);
        cmd(BTM, 2'h2, 11'h0);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(dq_oe), 32'hF);
        check(dq_out, e[0]);
        cmd(NOP, 2'h0, 11'h0);
        check(32'(dq_oe), 32'h0);
        $display("test data done");
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        resetn = 1'b0;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        check({dq_oe, bank_active, 13'h0, mode_word}, 32'h0);
        t_mode();
        t_banks();
        t_data();
        test_done();
    end
endmodule
